// ### core/pieb_pkg.sv
// pieb_pkg: constants for the peripheral interrupt enable bank.
// assumes: an Avalon-MM slave with 32-bit data, byte addresses, 8-bit regs.
package pieb_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [3:0] PIEB_OFS_ENABLE1 = 4'h0;
  localparam logic [3:0] PIEB_OFS_ENABLE2 = 4'h4;
  localparam logic [3:0] PIEB_OFS_ENABLE3 = 4'h8;
  localparam logic [3:0] PIEB_OFS_FLAGS1  = 4'hC;
  localparam logic [3:0] PIEB_OFS_FLAGS2  = 4'h0;
  localparam logic [3:0] PIEB_OFS_FLAGS3  = 4'h4;
  localparam logic [3:0] PIEB_OFS_CONTROL = 4'h8;
  localparam logic [3:0] PIEB_OFS_STATUS  = 4'hC;
  // page select: low page holds enables, high page flags and control
  localparam int         PIEB_PAGE_BIT    = 4;

  // field positions in the control register
  localparam int PIEB_CTRL_PERIPH_EN_BIT = 0;
  // field positions in the status register
  localparam int PIEB_STAT_REQUEST_BIT   = 0;
  localparam int PIEB_STAT_PERIPH_EN_BIT = 1;

  // values after reset
  localparam logic [7:0] PIEB_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PIEB_FLAG_RESET   = 8'h00;
  localparam logic       PIEB_CTRL_RESET   = 1'b0;

  // wait cycles from a new request to the answer
  localparam int PIEB_ANSWER_CYCLES = 1;

  // bus slave states
  typedef enum logic [0:0] {
    PIEB_IDLE,
    PIEB_ANSWER
  } pieb_bus_state_type;

endpackage : pieb_pkg

// ### core/pieb_flag_group.sv
// pieb_flag_group: one group of sticky interrupt flags and its gated request.
// assumes: event inputs are one-cycle pulses in the ref_clk domain.
`timescale 1ns/100ps

module pieb_flag_group #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] clear_mask,
  input  wire logic [WIDTH-1:0] enable,
  output logic      [WIDTH-1:0] flags,
  output logic                  request
);
  import pieb_pkg::*;

  logic [WIDTH-1:0] next_flags;

  initial begin
    if (WIDTH < 1 || WIDTH > 8) begin
      $error("pieb_flag_group: WIDTH must be 1 to 8");
    end
  end

  // set wins over clear so an event in the clearing cycle is kept
  always_comb begin
    next_flags = (flags & ~clear_mask) | event_in; // R16
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags <= PIEB_FLAG_RESET[WIDTH-1:0];
    end else if (clk_en) begin
      flags <= next_flags;
    end
  end

  // per-source gate: a flag only counts while its enable bit is 1
  assign request = |(flags & enable); // R19

endmodule : pieb_flag_group

// ### core/pieb_top.sv
// pieb_top: peripheral interrupt enable bank with flags and gated request.
// assumes: Avalon-MM master on ref_clk, peripherals pulse events synchronously.
//
// Functional notes
// R1: enable bits read/write, reset to zero
// R2: enable1 bit7 gates timer1 gate event
// R3: enable1 bit6 gates adc conversion done
// R4: enable1 bits5,4 gate serial receive, transmit
// R5: enable1 bits3,2 gate sync port1, collision
// R6: enable1 bits1,0 gate timer2 match, timer1 overflow
// R7: enable2 bit7 gates timer6 match
// R8: enable2 bits6,5 gate comparators b, a
// R9: enable2 bit4 gates flash task complete
// R10: enable2 bits3,2 gate sync port2, collision
// R11: enable2 bits1,0 gate timer4, oscillator rollover
// R12: enable3 bit7 gates oscillator fail
// R13: enable3 bit6 gates clock switch complete
// R14: enable3 bits5,4 gate timer3 gate, overflow
// R15: enable3 bits3..0 gate logic cells 4..1
// R16: flags set regardless of any enable
// R17: peripheral master enable gates all requests
// R18: software enables source before sleeping
// R19: request when flag, enable, master all set
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps

module pieb_top #(
  parameter int REG_WIDTH = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // group 1 events
  input  wire logic        timer1_gate_event,
  input  wire logic        adc_done_event,
  input  wire logic        uart_rx_event,
  input  wire logic        uart_tx_event,
  input  wire logic        sync_serial1_event,
  input  wire logic        sync_serial1_collision_event,
  input  wire logic        timer2_match_event,
  input  wire logic        timer1_overflow_event,
  // group 2 events
  input  wire logic        timer6_match_event,
  input  wire logic        comparator_b_event,
  input  wire logic        comparator_a_event,
  input  wire logic        flash_task_event,
  input  wire logic        sync_serial2_event,
  input  wire logic        sync_serial2_collision_event,
  input  wire logic        timer4_match_event,
  input  wire logic        num_osc_rollover_event,
  // group 3 events
  input  wire logic        osc_fail_event,
  input  wire logic        clock_switch_event,
  input  wire logic        timer3_gate_event,
  input  wire logic        timer3_overflow_event,
  input  wire logic [3:0]  logic_cell_event,
  // gated request toward the core
  output logic             periph_irq_request
);
  import pieb_pkg::*;

  initial begin
    if (REG_WIDTH != 8) begin
      $error("pieb_top: REG_WIDTH must be 8");
    end
    // the two-state slave serves exactly one wait cycle per access
    if (PIEB_ANSWER_CYCLES != 1) begin
      $error("pieb_top: the bus slave answers after one cycle only");
    end
    // the page select must be the top bit of the 5-bit address
    if (PIEB_PAGE_BIT != 4) begin
      $error("pieb_top: page select must be address bit 4");
    end
    // control and status fields live in the single data lane
    if (PIEB_CTRL_PERIPH_EN_BIT > 7) begin
      $error("pieb_top: control field outside lane 0");
    end
    if (PIEB_STAT_REQUEST_BIT > 7 || PIEB_STAT_PERIPH_EN_BIT > 7) begin
      $error("pieb_top: status field outside lane 0");
    end
    if (PIEB_STAT_REQUEST_BIT == PIEB_STAT_PERIPH_EN_BIT) begin
      $error("pieb_top: status fields overlap");
    end
    // distinct offsets, or one write would land in two registers
    if (PIEB_OFS_ENABLE1 == PIEB_OFS_ENABLE2 ||
        PIEB_OFS_ENABLE1 == PIEB_OFS_ENABLE3 ||
        PIEB_OFS_ENABLE2 == PIEB_OFS_ENABLE3) begin
      $error("pieb_top: enable register offsets overlap");
    end
    // status is left out: it shares the flags1 slot and is shadowed
    if (PIEB_OFS_FLAGS1 == PIEB_OFS_FLAGS2 ||
        PIEB_OFS_FLAGS1 == PIEB_OFS_FLAGS3 ||
        PIEB_OFS_FLAGS2 == PIEB_OFS_FLAGS3 ||
        PIEB_OFS_CONTROL == PIEB_OFS_FLAGS1 ||
        PIEB_OFS_CONTROL == PIEB_OFS_FLAGS2 ||
        PIEB_OFS_CONTROL == PIEB_OFS_FLAGS3) begin
      $error("pieb_top: flag or control offsets overlap");
    end
  end

  // enable registers and peripheral master enable
  logic [7:0] irq_enable_group1;
  logic [7:0] irq_enable_group2;
  logic [7:0] irq_enable_group3;
  logic       periph_irq_master_en;
  logic [7:0] next_irq_enable_group1;
  logic [7:0] next_irq_enable_group2;
  logic [7:0] next_irq_enable_group3;
  logic       next_periph_irq_master_en;

  // flag groups
  logic [7:0] event_group1;
  logic [7:0] event_group2;
  logic [7:0] event_group3;
  logic [7:0] flags_group1;
  logic [7:0] flags_group2;
  logic [7:0] flags_group3;
  logic [7:0] clear_group1;
  logic [7:0] clear_group2;
  logic [7:0] clear_group3;
  logic       request_group1;
  logic       request_group2;
  logic       request_group3;
  logic       any_source_request;

  // bus slave
  pieb_bus_state_type bus_state;
  pieb_bus_state_type next_bus_state;
  logic [31:0]        next_readdata;
  logic               request_taken;
  logic               write_taken;
  logic [7:0]         wdata_byte;

  // byte-lane merge: only lane 0 carries register data
  function automatic logic [7:0] merge_byte(input logic [7:0] old_value,
                                            input logic [7:0] new_value,
                                            input logic       lane_en);
    merge_byte = lane_en ? new_value : old_value;
  endfunction : merge_byte

  // match an address against a register offset within a page
  function automatic logic hit(input logic [4:0] addr,
                               input logic       page,
                               input logic [3:0] offset);
    hit = (addr[PIEB_PAGE_BIT] == page) && (addr[3:0] == offset);
  endfunction : hit

  // event bits gathered in register bit order, bit 7 first
  assign event_group1 = {timer1_gate_event, adc_done_event,      // R2 R3
                         uart_rx_event, uart_tx_event,           // R4
                         sync_serial1_event,                     // R5
                         sync_serial1_collision_event,           // R5
                         timer2_match_event,                     // R6
                         timer1_overflow_event};                 // R6
  assign event_group2 = {timer6_match_event,                     // R7
                         comparator_b_event, comparator_a_event, // R8
                         flash_task_event,                       // R9
                         sync_serial2_event,                     // R10
                         sync_serial2_collision_event,           // R10
                         timer4_match_event,                     // R11
                         num_osc_rollover_event};                // R11
  assign event_group3 = {osc_fail_event,                         // R12
                         clock_switch_event,                     // R13
                         timer3_gate_event,                      // R14
                         timer3_overflow_event,                  // R14
                         logic_cell_event};                      // R15

  // the master holds its request until waitrequest drops, so a request is
  // taken in the answer state; every access costs one wait cycle
  assign request_taken = (bus_state == PIEB_ANSWER) && (avs_read ||
                                                        avs_write);
  assign write_taken   = request_taken && avs_write && clk_en;
  assign wdata_byte    = avs_writedata[7:0];

  // flag clear: write one to clear, only in the taken cycle
  always_comb begin
    clear_group1 = 8'h00;
    clear_group2 = 8'h00;
    clear_group3 = 8'h00;
    if (write_taken && avs_byteenable[0]) begin
      if (hit(avs_address, 1'b1, PIEB_OFS_FLAGS1)) begin
        clear_group1 = wdata_byte;
      end
      if (hit(avs_address, 1'b1, PIEB_OFS_FLAGS2)) begin
        clear_group2 = wdata_byte;
      end
      if (hit(avs_address, 1'b1, PIEB_OFS_FLAGS3)) begin
        clear_group3 = wdata_byte;
      end
    end
  end

  pieb_flag_group #(
    .WIDTH (8)
  ) u_flags1 (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .event_in   (event_group1),
    .clear_mask (clear_group1),
    .enable     (irq_enable_group1),
    .flags      (flags_group1),
    .request    (request_group1)
  );

  pieb_flag_group #(
    .WIDTH (8)
  ) u_flags2 (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .event_in   (event_group2),
    .clear_mask (clear_group2),
    .enable     (irq_enable_group2),
    .flags      (flags_group2),
    .request    (request_group2)
  );

  pieb_flag_group #(
    .WIDTH (8)
  ) u_flags3 (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .event_in   (event_group3),
    .clear_mask (clear_group3),
    .enable     (irq_enable_group3),
    .flags      (flags_group3),
    .request    (request_group3)
  );

  // register writes; unmapped writes are accepted and dropped
  always_comb begin
    next_irq_enable_group1    = irq_enable_group1;
    next_irq_enable_group2    = irq_enable_group2;
    next_irq_enable_group3    = irq_enable_group3;
    next_periph_irq_master_en = periph_irq_master_en;
    if (write_taken) begin
      if (hit(avs_address, 1'b0, PIEB_OFS_ENABLE1)) begin
        next_irq_enable_group1 = merge_byte(irq_enable_group1, wdata_byte,
                                            avs_byteenable[0]); // R1
      end
      if (hit(avs_address, 1'b0, PIEB_OFS_ENABLE2)) begin
        next_irq_enable_group2 = merge_byte(irq_enable_group2, wdata_byte,
                                            avs_byteenable[0]); // R1
      end
      if (hit(avs_address, 1'b0, PIEB_OFS_ENABLE3)) begin
        next_irq_enable_group3 = merge_byte(irq_enable_group3, wdata_byte,
                                            avs_byteenable[0]); // R1
      end
      if (hit(avs_address, 1'b1, PIEB_OFS_CONTROL) &&
          avs_byteenable[0]) begin
        next_periph_irq_master_en = wdata_byte[PIEB_CTRL_PERIPH_EN_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_enable_group1    <= PIEB_ENABLE_RESET; // R1
      irq_enable_group2    <= PIEB_ENABLE_RESET; // R1
      irq_enable_group3    <= PIEB_ENABLE_RESET; // R1
      periph_irq_master_en <= PIEB_CTRL_RESET;
    end else if (clk_en) begin
      irq_enable_group1    <= next_irq_enable_group1;
      irq_enable_group2    <= next_irq_enable_group2;
      irq_enable_group3    <= next_irq_enable_group3;
      periph_irq_master_en <= next_periph_irq_master_en;
    end
  end

  // request is combinational so a new flag reaches the core at once
  assign any_source_request = request_group1 | request_group2 |
                              request_group3;
  assign periph_irq_request = any_source_request &
                              periph_irq_master_en; // R17 R19

  // bus state and read data; unmapped reads return zero
  always_comb begin
    next_bus_state = bus_state;
    next_readdata  = avs_readdata;
    case (bus_state)
      PIEB_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state = PIEB_ANSWER;
          next_readdata  = 32'h0000_0000;
          if (avs_read) begin
            if (hit(avs_address, 1'b0, PIEB_OFS_ENABLE1)) begin
              next_readdata[7:0] = irq_enable_group1; // R1
            end else if (hit(avs_address, 1'b0, PIEB_OFS_ENABLE2)) begin
              next_readdata[7:0] = irq_enable_group2; // R1
            end else if (hit(avs_address, 1'b0, PIEB_OFS_ENABLE3)) begin
              next_readdata[7:0] = irq_enable_group3; // R1
            end else if (hit(avs_address, 1'b1, PIEB_OFS_FLAGS1)) begin
              next_readdata[7:0] = flags_group1;
            end else if (hit(avs_address, 1'b1, PIEB_OFS_FLAGS2)) begin
              next_readdata[7:0] = flags_group2;
            end else if (hit(avs_address, 1'b1, PIEB_OFS_FLAGS3)) begin
              next_readdata[7:0] = flags_group3;
            end else if (hit(avs_address, 1'b1, PIEB_OFS_CONTROL)) begin
              next_readdata[PIEB_CTRL_PERIPH_EN_BIT] = periph_irq_master_en;
            end else if (hit(avs_address, 1'b1, PIEB_OFS_STATUS)) begin
              next_readdata[PIEB_STAT_REQUEST_BIT]   = periph_irq_request;
              next_readdata[PIEB_STAT_PERIPH_EN_BIT] = periph_irq_master_en;
            end
          end
        end
      end
      PIEB_ANSWER: begin
        next_bus_state = PIEB_IDLE;
      end
      default: begin
        next_bus_state = PIEB_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_state    <= PIEB_IDLE;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      bus_state    <= next_bus_state;
      avs_readdata <= next_readdata;
    end
  end

  // waitrequest low only in the answer cycle, and only while enabled
  assign avs_waitrequest = !((bus_state == PIEB_ANSWER) && clk_en);

endmodule : pieb_top

// ### testbench/pieb_props.sv
// pieb_props: bus timing and request gating checks on the bank ports.
// assumes: bound to pieb_top, one clock domain, synchronous reset.
`timescale 1ns/100ps

module pieb_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        periph_irq_request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // an access completes on the edge where waitrequest is low
  logic taken;
  assign taken = (avs_read | avs_write) & ~avs_waitrequest;

  // a fresh request always sees one wait cycle first
  AST_FIRST_WAIT: assert property (
    $rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("request answered without a wait cycle");
  AST_ONE_WAIT: assert property (
    $rose(avs_read | avs_write) && clk_en |=> !avs_waitrequest || !clk_en)
    else $error("answer late by more than one cycle");
  AST_LOW_ONCE: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");
  AST_CLKEN_HOLD: assert property (
    !clk_en |-> avs_waitrequest)
    else $error("answer given while clock enable is low");
  AST_UPPER_ZERO: assert property (
    avs_readdata[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  AST_UNMAPPED: assert property (
    avs_read && !avs_waitrequest && avs_address == 5'h0C
      |-> avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  AST_HOLD: assert property (
    !avs_read && !avs_write |=> $stable(avs_readdata))
    else $error("read data changed without an access");
  AST_AFTER_RESET: assert property (
    $fell(reset) |-> avs_waitrequest && !periph_irq_request
      && avs_readdata == 32'h0)
    else $error("state not cleared by reset");
  AST_MASTER_OFF: assert property (
    taken && avs_write && avs_address == 5'h18 && avs_byteenable[0]
      && !avs_writedata[0] |=> !periph_irq_request [*2])
    else $error("request high with master enable off");
  AST_REQ_FALL: assert property (
    $fell(periph_irq_request) |-> $past(taken && avs_write) || $past(reset))
    else $error("request dropped without a register write");

  // main scenarios reached
  cover property (taken && avs_write);
  cover property (taken && avs_read);
  cover property ($rose(periph_irq_request));
endmodule : pieb_props

// ### testbench/pieb_event_src.sv
// pieb_event_src: model of the peripherals that pulse interrupt events.
// assumes: events are single-cycle highs launched just after a clock edge.
`timescale 1ns/100ps

module pieb_event_src (
  input  wire logic       ref_clk,
  output logic      [7:0] ev_group1,
  output logic      [7:0] ev_group2,
  output logic      [7:0] ev_group3
);
  // quiet sources until told otherwise
  initial begin
    ev_group1 = 8'h00;
    ev_group2 = 8'h00;
    ev_group3 = 8'h00;
  end

  // sources fire whatever the enables say, as real peripherals do
  task automatic fire(input int grp, input logic [7:0] mask);
    @(posedge ref_clk);
    case (grp)
      0: ev_group1 <= mask;
      1: ev_group2 <= mask;
      default: ev_group3 <= mask;
    endcase
    @(posedge ref_clk);
    ev_group1 <= 8'h00;
    ev_group2 <= 8'h00;
    ev_group3 <= 8'h00;
  endtask : fire
endmodule : pieb_event_src

// ### testbench/pieb_top_bench.sv
// pieb_top_bench: register, flag and request tests of the enable bank.
// assumes: pieb_top, the event model pieb_event_src and pieb_props.
`timescale 1ns/100ps

module pieb_top_bench;
  import pieb_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        periph_irq_request;
  logic [7:0]  ev1, ev2, ev3;
  logic        timer1_gate_event, adc_done_event, uart_rx_event;
  logic        uart_tx_event, sync_serial1_event, timer2_match_event;
  logic        sync_serial1_collision_event, timer1_overflow_event;
  logic        timer6_match_event, comparator_b_event, comparator_a_event;
  logic        flash_task_event, sync_serial2_event, timer4_match_event;
  logic        sync_serial2_collision_event, num_osc_rollover_event;
  logic        osc_fail_event, clock_switch_event, timer3_gate_event;
  logic        timer3_overflow_event;
  logic [3:0]  logic_cell_event;
  logic [4:0]  en_addr [3] = '{5'h00, 5'h04, 5'h08};
  logic [4:0]  fl_addr [3] = '{5'h1C, 5'h10, 5'h14};
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // event vectors fan out to the named source pins, bit 7 first
  assign {timer1_gate_event, adc_done_event, uart_rx_event, uart_tx_event,
          sync_serial1_event, sync_serial1_collision_event,
          timer2_match_event, timer1_overflow_event} = ev1;
  assign {timer6_match_event, comparator_b_event, comparator_a_event,
          flash_task_event, sync_serial2_event,
          sync_serial2_collision_event, timer4_match_event,
          num_osc_rollover_event} = ev2;
  assign {osc_fail_event, clock_switch_event, timer3_gate_event,
          timer3_overflow_event, logic_cell_event} = ev3;

  pieb_top dut (.*);
  pieb_event_src src (
    .ref_clk   (ref_clk),
    .ev_group1 (ev1),
    .ev_group2 (ev2),
    .ev_group3 (ev3)
  );

  always #20 ref_clk = ~ref_clk;

  // hang guard: the full run needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus access, held until waitrequest is seen low at an edge
  task automatic access(input logic wr, input logic [4:0] a,
                        input logic [7:0] d, input logic [3:0] be,
                        output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : access

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    access(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 8'h00, 4'hF, q);
    chk(q, exp);
  endtask : rd_chk

  // request level checked one edge after its cause has landed
  task automatic req_chk(input logic exp);
    @(posedge ref_clk);
    chk({31'h0, periph_irq_request}, {31'h0, exp});
  endtask : req_chk

  initial begin
    logic [7:0]  m;
    logic [31:0] q;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    // reset values, then read back and refused writes
    for (int g = 0; g < 3; g++) rd_chk(en_addr[g], 32'h0);
    for (int g = 0; g < 3; g++) begin
      wr(en_addr[g], 8'hA5);
      rd_chk(en_addr[g], 32'hA5);
    end
    access(1'b1, en_addr[0], 8'h00, 4'hE, q);
    rd_chk(en_addr[0], 32'hA5);
    wr(5'h0C, 8'hFF);
    rd_chk(5'h0C, 32'h0);
    for (int g = 0; g < 3; g++) wr(en_addr[g], 8'h00);
    // flags set with every enable off, no request
    for (int g = 0; g < 3; g++) begin
      src.fire(g, 8'hFF);
      rd_chk(fl_addr[g], 32'hFF);
      req_chk(1'b0);
      wr(fl_addr[g], 8'hFF);
      rd_chk(fl_addr[g], 32'h0);
    end
    // each enable bit passes its own source and no other
    wr(5'h18, 8'h01);
    rd_chk(5'h18, 32'h01);
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < 8; b++) begin
        m = 8'h01 << b;
        wr(en_addr[g], m);
        src.fire(g, ~m);
        req_chk(1'b0);
        src.fire(g, m);
        req_chk(1'b1);
        wr(fl_addr[g], 8'hFF);
        req_chk(1'b0);
        wr(en_addr[g], 8'h00);
      end
    end
    // master enable gates a pending request
    wr(en_addr[0], 8'h01);
    src.fire(0, 8'h01);
    req_chk(1'b1);
    wr(5'h18, 8'h00);
    req_chk(1'b0);
    rd_chk(fl_addr[0], 32'h01);
    wr(5'h18, 8'h01);
    req_chk(1'b1);
    // an event in the clearing cycle wins, so the flag stays set
    wr(fl_addr[0], 8'hFF);
    req_chk(1'b0);
    fork
      wr(fl_addr[0], 8'hFF);
      begin
        @(posedge ref_clk);
        src.fire(0, 8'h01);
      end
    join
    rd_chk(fl_addr[0], 32'h01);
    // clock enable low stalls a read without losing it
    fork
      rd_chk(en_addr[0], 32'h01);
      begin
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join
    // a second reset clears enables and master enable
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(en_addr[0], 32'h0);
    rd_chk(5'h18, 32'h0);
    test_done();
  end
endmodule : pieb_top_bench

bind pieb_top pieb_props props (.*);
